// ==== hw/adcctl_top.sv ====
module adcctl_top (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_trigger_input_i,
  input wire logic alternate_clock_i,
  input wire logic async_conv_clock_i,
  input wire logic low_power_wait_i,
  input wire logic [10:0] sar_result_i,
  input wire logic [15:0] port_out_i,
  input wire logic [15:0] port_oe_n_i,
  input wire logic [15:0] port_pullup_i,
  input wire logic [15:0] pin_in_i,
  output logic [15:0] pin_out_o,
  output logic [15:0] pin_oe_n_o,
  output logic [15:0] pin_pullup_o,
  output logic [15:0] port_read_o,
  output logic converter_enable_o,
  output logic sar_sample_o,
  output logic converter_clock_tick_o,
  output logic complete_irq_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [4:0] channel_select_reg;
  logic complete_irq_enable_reg;
  logic continuous_reg;
  logic conv_complete_flag_reg;
  logic hw_trigger_enable_reg;
  logic compare_enable_reg;
  logic compare_gt_reg;
  logic [1:0] cmp_hi_reg;
  logic [7:0] cmp_lo_reg;
  logic [1:0] result_high_reg;
  logic [7:0] result_low_reg;
  adcctl_pkg::adcctl_cfg_t cfg_reg;
  logic [7:0] analog_pin_disable_mid_reg;
  logic [7:0] analog_pin_disable_upper_reg;
  logic active_reg;
  logic [5:0] tick_cnt_reg;
  logic cont_armed_reg;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic w_have_reg;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_addr = aw_addr_reg;
  assign wr_byte = w_data_reg[7:0];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  logic [3:0] w_strb_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  logic addr_ok_w;
  assign addr_ok_w = (wr_addr <= adcctl_pkg::OFF_PIN_UP) && (wr_addr[1:0] == 2'h0);
  logic wr_en;
  assign wr_en = wr_fire && w_strb_reg[0] && addr_ok_w;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adcctl_pkg::AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok_w ? adcctl_pkg::AXI_OKAY : adcctl_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_sc1;
  logic wr_mode_change;
  assign wr_sc1 = wr_en && wr_addr == adcctl_pkg::OFF_SC1;
  // A write to SC2, the configuration or either compare register makes a running conversion invalid
  assign wr_mode_change = wr_en && (wr_addr == adcctl_pkg::OFF_SC2
    || wr_addr == adcctl_pkg::OFF_CFG || wr_addr == adcctl_pkg::OFF_CMP_HI
    || wr_addr == adcctl_pkg::OFF_CMP_LO);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      channel_select_reg <= adcctl_pkg::CH_RESET;
      complete_irq_enable_reg <= 1'b0;
      continuous_reg <= 1'b0;
    end else if (wr_sc1) begin
      channel_select_reg <= wr_byte[adcctl_pkg::SC1_CH_LSB +: adcctl_pkg::CH_W];
      complete_irq_enable_reg <= wr_byte[adcctl_pkg::SC1_IEN];
      continuous_reg <= wr_byte[adcctl_pkg::SC1_CONT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hw_trigger_enable_reg <= 1'b0;
      compare_enable_reg <= 1'b0;
      compare_gt_reg <= 1'b0;
      cfg_reg <= '0;
      cmp_hi_reg <= 2'h0;
      cmp_lo_reg <= 8'h00;
      analog_pin_disable_mid_reg <= 8'h00;
      analog_pin_disable_upper_reg <= 8'h00;
    end else if (wr_en) begin
      unique case (wr_addr)
        adcctl_pkg::OFF_SC2: begin
          hw_trigger_enable_reg <= wr_byte[adcctl_pkg::SC2_TRG];
          compare_enable_reg <= wr_byte[adcctl_pkg::SC2_CFE];
          compare_gt_reg <= wr_byte[adcctl_pkg::SC2_CFGT];
        end
        adcctl_pkg::OFF_CFG: begin
          cfg_reg.div_sel <= wr_byte[adcctl_pkg::CFG_DIV_LSB +: 2];
          cfg_reg.mode <= wr_byte[adcctl_pkg::CFG_MODE_LSB +: 2];
          cfg_reg.clk_sel <= wr_byte[adcctl_pkg::CFG_CLK_LSB +: 2];
        end
        adcctl_pkg::OFF_CMP_HI: cmp_hi_reg <= wr_byte[1:0];
        adcctl_pkg::OFF_CMP_LO: cmp_lo_reg <= wr_byte;
        adcctl_pkg::OFF_PIN_MID: analog_pin_disable_mid_reg <= wr_byte;
        adcctl_pkg::OFF_PIN_UP: analog_pin_disable_upper_reg <= wr_byte;
        default: begin
        end
      endcase
    end
  end

  // Read side; reading the status clears nothing
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      adcctl_pkg::OFF_SC1: rd_byte = {conv_complete_flag_reg, complete_irq_enable_reg,
        continuous_reg, channel_select_reg};
      adcctl_pkg::OFF_SC2: rd_byte = {active_reg, hw_trigger_enable_reg,
        compare_enable_reg, compare_gt_reg, 4'h0};
      adcctl_pkg::OFF_RES_HI: rd_byte = {6'h00, result_high_reg};
      adcctl_pkg::OFF_RES_LO: rd_byte = result_low_reg;
      adcctl_pkg::OFF_CMP_HI: rd_byte = {6'h00, cmp_hi_reg};
      adcctl_pkg::OFF_CMP_LO: rd_byte = cmp_lo_reg;
      adcctl_pkg::OFF_CFG: rd_byte = {1'b0, cfg_reg.div_sel, 1'b0, cfg_reg.mode,
        cfg_reg.clk_sel};
      adcctl_pkg::OFF_PIN_MID: rd_byte = analog_pin_disable_mid_reg;
      adcctl_pkg::OFF_PIN_UP: rd_byte = analog_pin_disable_upper_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  logic rd_ok;
  assign rd_ok = (s_axi_araddr <= adcctl_pkg::OFF_PIN_UP) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= adcctl_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_ok ? adcctl_pkg::AXI_OKAY : adcctl_pkg::AXI_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock source select and divide
  // ---------------------------------------------------------------
  // External clocks are sampled as levels; their rising edges become ticks
  logic [1:0] alt_sync_reg;
  logic [1:0] async_sync_reg;
  logic alt_last_reg;
  logic async_last_reg;
  logic half_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      alt_sync_reg <= 2'h0;
      async_sync_reg <= 2'h0;
      alt_last_reg <= 1'b0;
      async_last_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      alt_sync_reg <= {alt_sync_reg[0], alternate_clock_i};
      async_sync_reg <= {async_sync_reg[0], async_conv_clock_i};
      alt_last_reg <= alt_sync_reg[1];
      async_last_reg <= async_sync_reg[1];
      half_reg <= !half_reg;
    end
  end

  logic src_tick;
  always_comb begin
    unique case (cfg_reg.clk_sel)
      adcctl_pkg::CLK_BUS: src_tick = 1'b1;
      adcctl_pkg::CLK_BUS_HALF: src_tick = half_reg;
      adcctl_pkg::CLK_ALT: src_tick = alt_sync_reg[1] && !alt_last_reg;
      adcctl_pkg::CLK_ASYNC: src_tick = async_sync_reg[1] && !async_last_reg;
    endcase
  end

  // Only the asynchronous source keeps ticking through low-power wait
  logic src_gated;
  assign src_gated = src_tick && (!low_power_wait_i ||
    cfg_reg.clk_sel == adcctl_pkg::CLK_ASYNC);

  logic conv_tick;
  adcctl_clkdiv u_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .src_tick_i(src_gated && active_reg),
    .div_sel_i(cfg_reg.div_sel),
    .clear_i(!active_reg),
    .tick_o(conv_tick)
  );

  // ---------------------------------------------------------------
  // Hardware trigger
  // ---------------------------------------------------------------
  logic [1:0] trg_sync_reg;
  logic trg_last_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trg_sync_reg <= 2'h0;
      trg_last_reg <= 1'b0;
    end else begin
      trg_sync_reg <= {trg_sync_reg[0], hw_trigger_input_i};
      trg_last_reg <= trg_sync_reg[1];
    end
  end

  logic disabled;
  logic hw_start;
  logic sw_start;
  assign disabled = channel_select_reg == adcctl_pkg::CH_ALL_ONES;
  assign hw_start = hw_trigger_enable_reg && trg_sync_reg[1] && !trg_last_reg
    && !active_reg && !cont_armed_reg;
  assign sw_start = wr_sc1 && !hw_trigger_enable_reg
    && wr_byte[adcctl_pkg::SC1_CH_LSB +: adcctl_pkg::CH_W] != adcctl_pkg::CH_ALL_ONES;

  // ---------------------------------------------------------------
  // Conversion sequencing and result
  // ---------------------------------------------------------------
  logic done;
  assign done = active_reg && conv_tick
    && tick_cnt_reg == 6'(adcctl_pkg::CONV_TICKS - 1);

  // Rounding: add the extra low bit, saturate at full scale
  logic [9:0] rounded;
  logic [10:0] sum10;
  logic [8:0] sum8;
  always_comb begin
    sum10 = {1'b0, sar_result_i[10:1]} + {10'h000, sar_result_i[0]};
    sum8 = {1'b0, sar_result_i[8:1]} + {8'h00, sar_result_i[0]};
    if (cfg_reg.mode == adcctl_pkg::MODE_10) begin
      rounded = sum10[10] ? 10'h3FF : sum10[9:0];
    end else begin
      rounded = {2'h0, sum8[8] ? 8'hFF : sum8[7:0]};
    end
  end

  logic [10:0] diff;
  logic cmp_true;
  logic [9:0] cmp_val;
  assign cmp_val = (cfg_reg.mode == adcctl_pkg::MODE_10) ? {cmp_hi_reg, cmp_lo_reg}
    : {2'h0, cmp_lo_reg};
  assign diff = {1'b0, rounded} - {1'b0, cmp_val};
  assign cmp_true = compare_gt_reg ? !diff[10] : diff[10];
  logic store;
  assign store = done && (!compare_enable_reg || cmp_true);
  logic [9:0] store_val;
  assign store_val = compare_enable_reg ? diff[9:0] : rounded;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      active_reg <= 1'b0;
      tick_cnt_reg <= 6'h00;
      cont_armed_reg <= 1'b0;
    end else if (wr_mode_change || (disabled && !wr_sc1)) begin
      active_reg <= 1'b0;
      tick_cnt_reg <= 6'h00;
      cont_armed_reg <= 1'b0;
    end else if (wr_sc1) begin
      // A status write aborts, then restarts only if the new channel is valid
      active_reg <= sw_start;
      tick_cnt_reg <= 6'h00;
      cont_armed_reg <= 1'b0;
    end else if (hw_start) begin
      active_reg <= 1'b1;
      tick_cnt_reg <= 6'h00;
      cont_armed_reg <= continuous_reg;
    end else if (done) begin
      active_reg <= continuous_reg;
      tick_cnt_reg <= 6'h00;
    end else if (active_reg && conv_tick) begin
      tick_cnt_reg <= tick_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      result_high_reg <= 2'h0;
      result_low_reg <= 8'h00;
    end else if (store) begin
      if (cfg_reg.mode == adcctl_pkg::MODE_10) begin
        result_high_reg <= store_val[9:8];
      end
      result_low_reg <= store_val[7:0];
    end
  end

  // Set wins over the clear that a status write causes
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      conv_complete_flag_reg <= 1'b0;
    end else if (store) begin
      conv_complete_flag_reg <= 1'b1;
    end else if (wr_sc1) begin
      conv_complete_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pin control and outputs
  // ---------------------------------------------------------------
  logic [15:0] pin_dis;
  assign pin_dis = {analog_pin_disable_upper_reg, analog_pin_disable_mid_reg};

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_out_o <= 16'h0000;
      pin_oe_n_o <= 16'hFFFF;
      pin_pullup_o <= 16'h0000;
      port_read_o <= 16'h0000;
      converter_enable_o <= 1'b0;
      sar_sample_o <= 1'b0;
      converter_clock_tick_o <= 1'b0;
      complete_irq_o <= 1'b0;
    end else begin
      pin_out_o <= port_out_i & ~pin_dis;
      pin_oe_n_o <= port_oe_n_i | pin_dis;
      pin_pullup_o <= port_pullup_i & ~pin_dis;
      port_read_o <= pin_in_i & ~pin_dis;
      converter_enable_o <= active_reg && !disabled;
      sar_sample_o <= active_reg && tick_cnt_reg == 6'h00;
      converter_clock_tick_o <= conv_tick;
      complete_irq_o <= conv_complete_flag_reg && complete_irq_enable_reg;
    end
  end

  a_pin_hiz: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (pin_dis[0] && $stable(pin_dis)) |=> pin_oe_n_o[0] && !pin_pullup_o[0])
    else $error("disabled pin still driven");
  a_read_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pin_dis[15] |=> port_read_o[15] == 1'b0)
    else $error("disabled pin read not zero");
  a_off_all_ones: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    disabled |-> !active_reg)
    else $error("converter active with channel all ones");
  a_flag_after: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    store |=> conv_complete_flag_reg ##1 (complete_irq_o == complete_irq_enable_reg))
    else $error("complete flag or irq wrong");
  a_trig_busy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (active_reg && hw_trigger_enable_reg) |-> !hw_start)
    else $error("trigger taken during conversion");
  a_hw_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (hw_start && !disabled && !wr_en) |=> active_reg && tick_cnt_reg == 6'h00)
    else $error("hardware trigger did not start");
  a_sw_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (sw_start && !disabled) |=> active_reg)
    else $error("software start lost");
  a_idle_done: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (done && !continuous_reg && !wr_en && !hw_start) |=> !active_reg ##1 !converter_enable_o)
    else $error("not idle after single conversion");
  a_low_only8: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (store && cfg_reg.mode == adcctl_pkg::MODE_8) |=> $stable(result_high_reg))
    else $error("high result written in 8-bit mode");

endmodule : adcctl_top

// ==== include/adcctl_pkg.sv ====
package adcctl_pkg;

  // Register byte offsets (AXI4-Lite, one aligned word each)
  localparam logic [7:0] OFF_SC1 = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_RES_HI = 8'h08;
  localparam logic [7:0] OFF_RES_LO = 8'h0C;
  localparam logic [7:0] OFF_CMP_HI = 8'h10;
  localparam logic [7:0] OFF_CMP_LO = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [7:0] OFF_PIN_MID = 8'h1C;
  localparam logic [7:0] OFF_PIN_UP = 8'h20;

  // Status/control one fields
  localparam int SC1_CONV_COMPLETE_FLAG = 7;
  localparam int SC1_IEN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC1_CH_LSB = 0;
  localparam int CH_W = 5;
  localparam logic [4:0] CH_ALL_ONES = 5'h1F;
  localparam logic [4:0] CH_RESET = 5'h1F;
  // Status/control two fields
  localparam int SC2_ACT = 7;
  localparam int SC2_TRG = 6;
  localparam int SC2_CFE = 5;
  localparam int SC2_CFGT = 4;
  // Configuration fields
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;

  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;

  // Conversion length in converter clock ticks
  localparam int CONV_TICKS = 20;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] div_sel;
    logic [1:0] mode;
    logic [1:0] clk_sel;
  } adcctl_cfg_t;

endpackage : adcctl_pkg

// ==== hw/adcctl_clkdiv.sv ====
module adcctl_clkdiv (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic src_tick_i,
  input wire logic [1:0] div_sel_i,
  input wire logic clear_i,
  output logic tick_o
);

  logic [2:0] cnt_reg;
  logic [2:0] limit;

  // Divide ratios 1, 2, 4, 8
  always_comb begin
    unique case (div_sel_i)
      2'h0: limit = 3'h0;
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      2'h3: limit = 3'h7;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || clear_i) begin
      cnt_reg <= 3'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (src_tick_i) begin
        if (cnt_reg >= limit) begin
          cnt_reg <= 3'h0;
          tick_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end
    end
  end

  a_div_one: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (div_sel_i == 2'h0 && src_tick_i && !clear_i && $stable(div_sel_i)
      && cnt_reg == 3'h0) |=> tick_o)
    else $error("divide by one lost a tick");

endmodule : adcctl_clkdiv

// ==== verif/adcctl_far_model.sv ====
module adcctl_far_model (
  input wire logic clock_i,
  input wire logic fire_i,
  output logic trig_o,
  output logic alt_clk_o,
  output logic async_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Clocks of the other sources: the alternate one runs locked to the bus clock at a quarter of its rate, the async one unrelated in phase
  // --------
  logic [1:0] hold_reg = 2'h0;
  logic trig_reg = 1'b0;
  logic alt_reg = 1'b0;
  logic async_reg = 1'b0;
  assign trig_o = trig_reg;
  assign alt_clk_o = alt_reg;
  assign async_clk_o = async_reg;
  always #16 alt_reg = ~alt_reg;
  always #33 async_reg = ~async_reg;
  // Trigger held a few cycles so the two-stage synchroniser cannot miss it
  always @(posedge clock_i) begin
    hold_reg <= fire_i ? 2'h3 : hold_reg - {1'b0, hold_reg != 2'h0};
    trig_reg <= fire_i | (hold_reg != 2'h0);
  end
endmodule : adcctl_far_model

// ==== verif/test_adcctl_top.sv ====
module test_adcctl_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic hw_trigger_input_i, alternate_clock_i, async_conv_clock_i, low_power_wait_i, fire;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic converter_enable_o, sar_sample_o, converter_clock_tick_o, complete_irq_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, w, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [10:0] sar_result_i;
  logic [15:0] port_out_i, port_oe_n_i, port_pullup_i, pin_in_i, pin_out_o, pin_oe_n_o;
  logic [15:0] pin_pullup_o, port_read_o;
  logic [9:0] e;
  logic [31:0] seed = 32'h0000E0B2;
  int err_count = 0;
  int check_count = 0;
  int k, c, x;

  adcctl_top uut (.*);
  adcctl_far_model far (.clock_i(clock_i), .fire_i(fire), .trig_o(hw_trigger_input_i),
    .alt_clk_o(alternate_clock_i), .async_clk_o(async_conv_clock_i));
  always #4 clock_i = ~clock_i;

  // --------
  // Helpers
  // --------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Drop the extra bit with round-half-up; full scale saturates
  function automatic logic [9:0] rounded(input logic [10:0] s, input logic ten);
    logic [9:0] h;
    h = ten ? s[10:1] : {2'h0, s[8:1]};
    return (h == (ten ? 10'h3FF : 10'h0FF)) ? h : h + {9'h0, s[0]};
  endfunction : rounded
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic tmo();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    final_report();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_lvl(ref logic s, input logic lvl);
    int n;
    for (n = 0; n < 600 && s !== lvl; n++) @(posedge clock_i);
    if (n == 600) tmo();
  endtask : wait_lvl
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    int n;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 200) tmo();
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 200) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask : rdc

  // --------
  // Main sequence
  // --------
  initial begin
    {rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sar_result_i, low_power_wait_i, fire} = '0;
    {port_out_i, port_oe_n_i, port_pullup_i, pin_in_i} = '0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk(pin_oe_n_o, 32'h0000FFFF);
    chk(converter_enable_o, 32'h0);
    rdc(adcctl_pkg::OFF_SC1, 32'h0000001F);
    rdc(adcctl_pkg::OFF_CFG, 32'h0);
    rd(8'h24);
    chk(r, adcctl_pkg::AXI_SLVERR);
    wr(adcctl_pkg::OFF_SC1, 32'h0000001F);
    repeat (5) @(posedge clock_i);
    chk(converter_enable_o, 32'h0);
    for (k = 0; k < 4; k++) begin
      v = (k == 0) ? 32'h00000180 : rnd();
      w = rnd();
      port_oe_n_i <= w[15:0];
      port_pullup_i <= w[31:16];
      port_out_i <= ~w[15:0];
      pin_in_i <= v[31:16];
      wr(adcctl_pkg::OFF_PIN_MID, {24'h0, v[7:0]});
      wr(adcctl_pkg::OFF_PIN_UP, {24'h0, v[15:8]});
      repeat (3) @(posedge clock_i);
      chk(pin_oe_n_o, w[15:0] | v[15:0]);
      chk(pin_out_o, 16'(~w[15:0] & ~v[15:0]));
      chk(port_read_o, v[31:16] & ~v[15:0]);
      chk(pin_pullup_o, w[31:16] & ~v[15:0]);
      rdc(adcctl_pkg::OFF_PIN_MID, {24'h0, v[7:0]});
      rdc(adcctl_pkg::OFF_PIN_UP, {24'h0, v[15:8]});
    end
    // Saturation and smallest codes first, then random ones, in both modes
    for (k = 0; k < 6; k++) begin
      v = (k < 2) ? 32'h7FF : ((k < 4) ? 32'h1 : rnd());
      sar_result_i <= v[10:0];
      wr(adcctl_pkg::OFF_CFG, {28'h0, k[0] ? adcctl_pkg::MODE_10 : adcctl_pkg::MODE_8, 2'h0});
      wr(adcctl_pkg::OFF_SC1, 32'h00000040);
      @(posedge clock_i);
      chk(sar_sample_o, 32'h1);
      wait_lvl(complete_irq_o, 1'b1);
      chk(converter_enable_o, 32'h0);
      e = rounded(v[10:0], k[0]);
      if (k[0]) rdc(adcctl_pkg::OFF_RES_HI, {30'h0, e[9:8]});
      rdc(adcctl_pkg::OFF_RES_LO, {24'h0, e[7:0]});
      rdc(adcctl_pkg::OFF_SC1, 32'h000000C0);
    end
    // Compare: a true upper limit stores the difference, a false lower limit nothing
    sar_result_i <= 11'h400;
    wr(adcctl_pkg::OFF_CMP_HI, 32'h1);
    wr(adcctl_pkg::OFF_CMP_LO, 32'h23);
    e = rounded(11'h400, 1'b1) - 10'h123;
    for (k = 0; k < 2; k++) begin
      wr(adcctl_pkg::OFF_SC2, k ? 32'h20 : 32'h30);
      wr(adcctl_pkg::OFF_SC1, 32'h00000040);
      repeat (40) @(posedge clock_i);
      chk(complete_irq_o, k ? 32'h0 : 32'h1);
      rdc(adcctl_pkg::OFF_RES_LO, {24'h0, e[7:0]});
      rdc(adcctl_pkg::OFF_RES_HI, {30'h0, e[9:8]});
    end
    wr(adcctl_pkg::OFF_CFG, 32'h0);
    wr(adcctl_pkg::OFF_SC2, 32'h00000040);
    wr(adcctl_pkg::OFF_SC1, 32'h0);
    repeat (30) @(posedge clock_i);
    chk(converter_enable_o, 32'h0);
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    wait_lvl(converter_enable_o, 1'b1);
    repeat (5) @(posedge clock_i);
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    wait_lvl(converter_enable_o, 1'b0);
    repeat (10) @(posedge clock_i);
    chk(converter_enable_o, 32'h0);
    chk(complete_irq_o, 32'h0);
    rdc(adcctl_pkg::OFF_SC1, 32'h00000080);
    // Continuous with hardware trigger: one edge launches a run that keeps going
    wr(adcctl_pkg::OFF_SC1, 32'h00000020);
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    wait_lvl(converter_enable_o, 1'b1);
    repeat (70) @(posedge clock_i);
    chk(converter_enable_o, 32'h1);
    rdc(adcctl_pkg::OFF_SC1, 32'h000000A0);
    wr(adcctl_pkg::OFF_SC2, 32'h0);
    // Every source, divider and wait state: ticks seen in a 16-cycle window
    for (k = 0; k < 32; k++) begin
      low_power_wait_i <= k[4];
      wr(adcctl_pkg::OFF_CFG, {25'h0, k[3:2], 3'h0, k[1:0]});
      wr(adcctl_pkg::OFF_SC1, 32'h0);
      c = 0;
      repeat (16) begin
        @(posedge clock_i);
        c += int'(converter_clock_tick_o);
      end
      x = (k[4] && k[1:0] != 2'h3) ? 0 : 16 >> (k % 4 + (k / 4) % 4);
      chk(32'(c <= x + 1 && c + 1 >= x), 32'h1);
    end
    final_report();
  end
endmodule : test_adcctl_top
